/* hw/tsc_arrival_stamp.sv */
// arrival time stamp capture with clock enables, reference select and reference check
`timescale 1ns/1ps
`include "tsc_consts.svh"

// Functional notes
// R1: stamp counter is 33 bits, two sections
// R2: lower 5 bits count 0..24, divide 25
// R3: upper 28 bits step when lower is 24
// R4: software presets both sections, starts, stops
// R5: enabled trigger writes counter into FIFO
// R6: each input selects rising, falling or both
// R7: each entry records which conditions fired
// R8: entry read as two holding words
// R9: pop follows host read order, halves match
// R10: derive 100, 20, 10, 2 MHz rates
// R11: software selects internal or external reference
// R12: selected reference drives stamp and outputs; stamp runs from the core clock, only the outputs follow it
// R13: internal and external check counters run together
// R14: software clears, starts, sets check end
// R15: check end count sets done status
// R16: external check count readable by software
// R17: low word holds entry bits 31..0
// R18: high word holds 40..32 plus flags
// R19: full FIFO drops triggers, keeps entries
// R20: outside triggers synchronised, one capture each
module tsc_arrival_stamp (
   input  wire logic                 core_clk,
   input  wire logic                 rst_n,
   input  wire tsc_pkg::tsc_bus_req_t busReq,
   output logic [31:0]               busRdata,
   input  wire logic                 blank1Pin,
   input  wire logic                 blank2Pin,
   input  wire logic                 ppsPin,
   input  wire logic                 ext10Pin,
   input  wire logic                 arrayStrobe,
   output logic                      stampClkOut,
   output logic                      ref10OutA,
   output logic                      ref10OutB,
   output tsc_pkg::tsc_ticks_t       ticksOut
);

   // ---------------- rate enables from the core clock
   logic [7:0]  accReg;
   logic [8:0]  accSum;
   logic [2:0]  div20Reg;
   logic        div10Reg;
   logic [3:0]  div2Reg;
   logic        tick100;
   logic        tick20;
   logic        tick10;
   logic        tick2;
   logic        int10SqReg;

   // fractional step keeps the 100 MHz mean rate exact, at the cost of jitter
   assign accSum  = {1'b0, accReg} + 9'(`TSC_BASE_MHZ);
   assign tick100 = (accSum >= 9'(`TSC_CORE_MHZ));                          // [R10]
   assign tick20  = tick100 && (div20Reg == `TSC_DIV20_LAST);               // [R10]
   assign tick10  = tick20 && (div10Reg == `TSC_DIV10_LAST);                // [R10]
   assign tick2   = tick20 && (div2Reg == `TSC_DIV2_LAST);                  // [R10]

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         accReg   <= 8'h00;
         div20Reg <= 3'h0;
         div10Reg <= 1'h0;
         div2Reg  <= 4'h0;
      end else begin
         accReg <= tick100 ? 8'(accSum - 9'(`TSC_CORE_MHZ)) : accSum[7:0];
         if (tick100) begin
            div20Reg <= (div20Reg == `TSC_DIV20_LAST) ? 3'h0 : div20Reg + 3'h1;
         end
         if (tick20) begin
            div10Reg <= ~div10Reg;
            div2Reg  <= (div2Reg == `TSC_DIV2_LAST) ? 4'h0 : div2Reg + 4'h1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ticksOut   <= '0;
         int10SqReg <= 1'b0;
      end else begin
         ticksOut   <= '{tick100: tick100, tick20: tick20, tick10: tick10, tick2: tick2};
         if (tick20) begin
            int10SqReg <= ~int10SqReg;
         end
      end
   end

   // ---------------- pin synchronisers: {ext10, pps, blank2, blank1}
   logic [3:0] pinIn;
   logic [3:0] sync1Reg;
   logic [3:0] sync2Reg;
   logic [3:0] sync3Reg;
   logic [3:0] filtReg;

   assign pinIn = {ext10Pin, ppsPin, blank2Pin, blank1Pin};

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1Reg <= 4'h0;
         sync2Reg <= 4'h0;
         sync3Reg <= 4'h0;
         filtReg  <= 4'h0;
      end else begin
         sync1Reg <= pinIn;                                                 // [R20]
         sync2Reg <= sync1Reg;
         sync3Reg <= sync2Reg;
         // a level is accepted only once two stages agree
         filtReg  <= (~(sync2Reg ^ sync3Reg) & sync3Reg)
                   | ((sync2Reg ^ sync3Reg) & filtReg);                    // [R20]
      end
   end

   // ---------------- register file
   logic        chkRunReg;
   logic        refSelExtReg;
   logic        chkDoneReg;
   logic [31:0] chkEndReg;
   logic [31:0] chkIntCntReg;
   logic [31:0] chkExtCntReg;
   logic [4:0]  presetLowReg;
   logic [27:0] presetHighReg;
   logic        toaRunReg;
   logic [7:0]  trigEnReg;
   logic        chkClrPulse;
   logic        toaLoadPulse;
   logic        wrChk;
   logic        wrToa;

   assign wrChk        = busReq.wr && (busReq.addr == `TSC_OFF_CHK_CTRL);
   assign wrToa        = busReq.wr && (busReq.addr == `TSC_OFF_TOA_CTRL);
   assign chkClrPulse  = wrChk && busReq.wdata[`TSC_CHK_CLR_BIT];
   assign toaLoadPulse = wrToa && busReq.wdata[`TSC_TOA_LOAD_BIT];

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         chkRunReg     <= 1'b0;
         refSelExtReg  <= 1'b0;
         chkEndReg     <= `TSC_CHK_END_RST;
         presetLowReg  <= 5'h00;
         presetHighReg <= 28'h000_0000;
         toaRunReg     <= 1'b0;
         trigEnReg     <= `TSC_TRIG_RST;
      end else if (busReq.wr) begin
         unique case (busReq.addr)
            `TSC_OFF_CHK_CTRL: begin
               chkRunReg    <= busReq.wdata[`TSC_CHK_RUN_BIT];             // [R14]
               refSelExtReg <= busReq.wdata[`TSC_CHK_SEL_BIT];             // [R11]
            end
            `TSC_OFF_CHK_END:   chkEndReg     <= busReq.wdata;             // [R14]
            `TSC_OFF_TOA_LOW:   presetLowReg  <= busReq.wdata[4:0];        // [R4]
            `TSC_OFF_TOA_HIGH:  presetHighReg <= busReq.wdata[27:0];       // [R4]
            `TSC_OFF_TOA_CTRL:  toaRunReg     <= busReq.wdata[`TSC_TOA_RUN_BIT]; // [R4]
            `TSC_OFF_TRIG_CTRL: trigEnReg     <= busReq.wdata[7:0];        // [R6]
            default: begin
            end
         endcase
      end
   end

   // ---------------- reference select and outputs
   logic selRefSq;
   logic stampPhReg;
   logic stampTick;

   assign selRefSq  = refSelExtReg ? filtReg[3] : int10SqReg;               // [R11]
   // no on-chip multiplier: the 125 MHz phase runs from the core clock,
   // only the reference outputs follow the selected source
   assign stampTick = stampPhReg;                                          // [R12]

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         stampPhReg  <= 1'b0;
         stampClkOut <= 1'b0;
         ref10OutA   <= 1'b0;
         ref10OutB   <= 1'b0;
      end else begin
         stampPhReg  <= ~stampPhReg;
         stampClkOut <= stampPhReg;                                        // [R12]
         ref10OutA   <= selRefSq;                                          // [R12]
         ref10OutB   <= selRefSq;                                          // [R12]
      end
   end

   // ---------------- reference check counters
   logic ext10PrevReg;
   logic ext10Edge;
   logic chkActive;
   logic doneSet;

   assign ext10Edge = filtReg[3] && !ext10PrevReg;
   assign chkActive = chkRunReg && !chkDoneReg;
   assign doneSet   = chkActive && (chkIntCntReg == chkEndReg);            // [R15]

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ext10PrevReg <= 1'b0;
         chkIntCntReg <= 32'h0000_0000;
         chkExtCntReg <= 32'h0000_0000;
      end else begin
         ext10PrevReg <= filtReg[3];
         if (chkClrPulse) begin
            chkIntCntReg <= 32'h0000_0000;                                 // [R14]
            chkExtCntReg <= 32'h0000_0000;
         end else if (chkActive && !doneSet) begin
            if (tick10) begin
               chkIntCntReg <= chkIntCntReg + 32'h0000_0001;               // [R13]
            end
            if (ext10Edge) begin
               chkExtCntReg <= chkExtCntReg + 32'h0000_0001;               // [R13]
            end
         end
      end
   end

   // completion beats a clear written in the same cycle
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         chkDoneReg <= 1'b0;
      end else if (doneSet) begin
         chkDoneReg <= 1'b1;                                               // [R15]
      end else if (chkClrPulse) begin
         chkDoneReg <= 1'b0;
      end
   end

   // ---------------- arrival time counter
   logic [4:0]  lowCntReg;
   logic [27:0] highCntReg;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         lowCntReg  <= 5'h00;
         highCntReg <= 28'h000_0000;
      end else if (toaLoadPulse) begin
         lowCntReg  <= presetLowReg;                                       // [R4]
         highCntReg <= presetHighReg;
      end else if (toaRunReg && stampTick) begin
         if (lowCntReg == `TSC_LOW_WRAP) begin
            lowCntReg  <= 5'h00;                                           // [R2]
            highCntReg <= highCntReg + 28'h000_0001;                       // [R3]
         end else begin
            lowCntReg  <= lowCntReg + 5'h01;                               // [R2]
         end
      end
   end

   // ---------------- trigger conditions
   logic [3:0] trigLvl;
   logic [3:0] trigPrevReg;
   logic [7:0] trigCond;
   logic       trigFire;

   assign trigLvl = {arrayStrobe, filtReg[2:0]};

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         trigCond[2*i]   = trigEnReg[2*i] && trigLvl[i] && !trigPrevReg[i];     // [R6]
         trigCond[2*i+1] = trigEnReg[2*i+1] && !trigLvl[i] && trigPrevReg[i];   // [R6]
      end
   end

   assign trigFire = |trigCond;                                            // [R5]

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         trigPrevReg <= 4'h0;
      end else begin
         trigPrevReg <= trigLvl;                                           // [R20]
      end
   end

   // ---------------- capture FIFO
   logic [`TSC_FIFO_AW-1:0] wrPtrReg;
   logic [`TSC_FIFO_AW-1:0] rdPtrReg;
   logic [`TSC_FIFO_AW:0]   fillReg;
   logic                    fifoFull;
   logic                    fifoEmpty;
   logic                    push;
   logic                    pop;
   tsc_pkg::tsc_entry_t     pushEntry;
   tsc_pkg::tsc_entry_t     memRdData;
   tsc_pkg::tsc_hold_state_t holdState;

   assign fifoFull  = (fillReg == (`TSC_FIFO_AW+1)'(`TSC_FIFO_DEPTH));     // [R19]
   assign fifoEmpty = (fillReg == '0);
   assign push      = trigFire && !fifoFull;                               // [R19]
   assign pop       = (holdState == tsc_pkg::HS_FETCH) && !fifoEmpty;      // [R9]
   assign pushEntry = '{cause: trigCond, high: highCntReg, low: lowCntReg}; // [R1] [R7]

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtrReg <= '0;
         rdPtrReg <= '0;
         fillReg  <= '0;
      end else begin
         if (push) begin
            wrPtrReg <= wrPtrReg + 1'b1;                                   // [R5]
         end
         if (pop) begin
            rdPtrReg <= rdPtrReg + 1'b1;
         end
         if (push && !pop) begin
            fillReg <= fillReg + 1'b1;
         end else if (pop && !push) begin
            fillReg <= fillReg - 1'b1;
         end
      end
   end

   tsc_fifo_mem u_mem (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .wrEn     (push),
      .wrAddr   (wrPtrReg),
      .wrData   (pushEntry),
      .rdEn     (pop),
      .rdAddr   (rdPtrReg),
      .rdData   (memRdData)
   );

   // ---------------- holding registers driven by host read order
   tsc_pkg::tsc_entry_t holdReg;
   logic                holdValid;
   logic                rdLo;
   logic                rdHi;

   assign rdLo      = busReq.rd && (busReq.addr == `TSC_OFF_FIFO_LO);
   assign rdHi      = busReq.rd && (busReq.addr == `TSC_OFF_FIFO_HI);
   assign holdValid = (holdState == tsc_pkg::HS_HELD) || (holdState == tsc_pkg::HS_LOWDONE);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         holdState <= tsc_pkg::HS_FETCH;
      end else begin
         unique case (holdState)
            tsc_pkg::HS_FETCH:   if (pop) holdState <= tsc_pkg::HS_LOAD;
            tsc_pkg::HS_LOAD:    holdState <= tsc_pkg::HS_HELD;
            tsc_pkg::HS_HELD: begin
               if (rdHi) begin
                  holdState <= tsc_pkg::HS_FETCH;                          // [R9]
               end else if (rdLo) begin
                  holdState <= tsc_pkg::HS_LOWDONE;                        // [R9]
               end
            end
            tsc_pkg::HS_LOWDONE: if (rdHi) holdState <= tsc_pkg::HS_FETCH; // [R9]
         endcase
      end
   end

   // the hold only changes in LOAD, so both halves stay one entry
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         holdReg <= '0;
      end else if (holdState == tsc_pkg::HS_LOAD) begin
         holdReg <= memRdData;                                             // [R8]
      end
   end

   // ---------------- read data, one cycle after the strobe
   logic [31:0] rdMux;

   always_comb begin
      rdMux = 32'h0000_0000;
      unique case (busReq.addr)
         `TSC_OFF_CHK_CTRL: begin
            rdMux[`TSC_CHK_RUN_BIT]  = chkRunReg;
            rdMux[`TSC_CHK_SEL_BIT]  = refSelExtReg;
            rdMux[`TSC_CHK_DONE_BIT] = chkDoneReg;                         // [R15]
         end
         `TSC_OFF_CHK_END:   rdMux = chkEndReg;
         `TSC_OFF_CHK_INT:   rdMux = chkIntCntReg;
         `TSC_OFF_CHK_EXT:   rdMux = chkExtCntReg;                         // [R16]
         `TSC_OFF_TOA_LOW:   rdMux[4:0] = lowCntReg;
         `TSC_OFF_TOA_HIGH:  rdMux[27:0] = highCntReg;
         `TSC_OFF_TOA_CTRL:  rdMux[`TSC_TOA_RUN_BIT] = toaRunReg;
         `TSC_OFF_TRIG_CTRL: rdMux[7:0] = trigEnReg;
         `TSC_OFF_FIFO_LO:   rdMux = holdValid ? holdReg[31:0] : 32'h0000_0000; // [R17]
         `TSC_OFF_FIFO_HI: begin
            rdMux[8:0]               = holdValid ? holdReg[40:32] : 9'h000; // [R18]
            rdMux[`TSC_HI_EMPTY_BIT] = fifoEmpty;                          // [R18]
            rdMux[`TSC_HI_FULL_BIT]  = fifoFull;                           // [R19]
            rdMux[`TSC_HI_VALID_BIT] = holdValid;
         end
         default: rdMux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         busRdata <= 32'h0000_0000;
      end else if (busReq.rd) begin
         busRdata <= rdMux;
      end else begin
         busRdata <= 32'h0000_0000;
      end
   end

endmodule

/* hw/tsc_consts.svh */
// offsets, field positions, reset values and divider counts of the arrival stamp block
`ifndef TSC_CONSTS_SVH
`define TSC_CONSTS_SVH

`define TSC_OFF_CHK_CTRL   8'h0C
`define TSC_OFF_CHK_INT    8'h50
`define TSC_OFF_CHK_END    8'h54
`define TSC_OFF_TOA_LOW    8'h5C
`define TSC_OFF_TOA_HIGH   8'h60
`define TSC_OFF_TOA_CTRL   8'h64
`define TSC_OFF_TRIG_CTRL  8'h88
`define TSC_OFF_FIFO_LO    8'h8C
`define TSC_OFF_FIFO_HI    8'h90
`define TSC_OFF_CHK_EXT    8'hA8

`define TSC_CHK_RUN_BIT    0
`define TSC_CHK_CLR_BIT    1
`define TSC_CHK_SEL_BIT    2
`define TSC_CHK_DONE_BIT   3
`define TSC_TOA_RUN_BIT    0
`define TSC_TOA_LOAD_BIT   1
`define TSC_HI_EMPTY_BIT   9
`define TSC_HI_FULL_BIT    10
`define TSC_HI_VALID_BIT   11

`define TSC_CHK_END_RST    32'h0000_2710
`define TSC_TRIG_RST       8'h00

`define TSC_LOW_WRAP       5'h18
`define TSC_FIFO_AW        4
`define TSC_FIFO_DEPTH     16
`define TSC_CORE_MHZ       250
`define TSC_BASE_MHZ       100
`define TSC_DIV20_LAST     3'h4
`define TSC_DIV10_LAST     1'h1
`define TSC_DIV2_LAST      4'h9

`endif

/* hw/tsc_pkg.sv */
// types shared by the arrival stamp block
package tsc_pkg;

   typedef enum logic [1:0] {
      HS_FETCH   = 2'b00,
      HS_LOAD    = 2'b01,
      HS_HELD    = 2'b11,
      HS_LOWDONE = 2'b10
   } tsc_hold_state_t;

   typedef struct packed {
      logic [7:0]  cause;
      logic [27:0] high;
      logic [4:0]  low;
   } tsc_entry_t;

   typedef struct packed {
      logic tick100;
      logic tick20;
      logic tick10;
      logic tick2;
   } tsc_ticks_t;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } tsc_bus_req_t;

endpackage

/* hw/tsc_fifo_mem.sv */
// capture entry storage with registered read data
`timescale 1ns/1ps
`include "tsc_consts.svh"

module tsc_fifo_mem (
   input  wire logic                     core_clk,
   input  wire logic                     rst_n,
   input  wire logic                     wrEn,
   input  wire logic [`TSC_FIFO_AW-1:0]  wrAddr,
   input  wire tsc_pkg::tsc_entry_t      wrData,
   input  wire logic                     rdEn,
   input  wire logic [`TSC_FIFO_AW-1:0]  rdAddr,
   output tsc_pkg::tsc_entry_t           rdData
);

   tsc_pkg::tsc_entry_t memArray [`TSC_FIFO_DEPTH];

   // array left without reset so it maps onto block storage
   always_ff @(posedge core_clk) begin
      if (wrEn) begin
         memArray[wrAddr] <= wrData;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdData <= '0;
      end else if (rdEn) begin
         rdData <= memArray[rdAddr];
      end
   end

endmodule

/* verif/tsc_ext_ref.sv */
// external 10 MHz reference source feeding the stamp block
`timescale 1ns/1ps

module tsc_ext_ref (
   input  wire logic en,
   output logic      ext10Pin
);
   // parked low when disabled, no free-running edges leak in
   always begin
      ext10Pin = 1'b0;
      forever #50 ext10Pin = en ? ~ext10Pin : 1'b0;
   end
endmodule

/* verif/tsc_stamp_checker_assertions.sv */
// port-level checks for the arrival stamp block
`timescale 1ns/1ps
`include "tsc_consts.svh"

module tsc_stamp_checker (
   input wire logic                  core_clk,
   input wire logic                  rst_n,
   input wire tsc_pkg::tsc_bus_req_t busReq,
   input wire logic [31:0]           busRdata,
   input wire logic                  stampClkOut,
   input wire logic                  ref10OutA,
   input wire logic                  ref10OutB,
   input wire tsc_pkg::tsc_ticks_t   ticksOut
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic hiRd;
   assign hiRd = busReq.rd && busReq.addr == `TSC_OFF_FIFO_HI;

   read_idle_a: assert property (!$past(busReq.rd) |-> busRdata == 32'h0)
      else $error("read data not zero outside answer cycle");
   unmapped_zero_a: assert property (busReq.rd && busReq.addr == 8'hFC |=> busRdata == 32'h0)
      else $error("unmapped read not zero");
   hold_invalid_a: assert property ($past(hiRd) && !busRdata[11] |-> busRdata[8:0] == 9'h0)
      else $error("invalid holding word carries data");
   empty_full_a: assert property ($past(hiRd) |-> !(busRdata[9] && busRdata[10]))
      else $error("fifo empty and full together");
   stamp_toggle_a: assert property ($past(rst_n) |=> stampClkOut != $past(stampClkOut))
      else $error("stamp clock did not toggle");
   ref_pair_a: assert property (ref10OutA == ref10OutB)
      else $error("reference outputs differ");
   ref_half_a: assert property ($rose(ref10OutA) |-> ##[1:30] $fell(ref10OutA))
      else $error("reference high phase too long");
   tick10_gap_a: assert property (ticksOut.tick10 |=>
      !ticksOut.tick10 [*8] ##[1:20] ticksOut.tick10)
      else $error("10 MHz tick spacing wrong");
   tick20_gap_a: assert property (ticksOut.tick20 |=> !ticksOut.tick20 [*8])
      else $error("20 MHz ticks too close");
   tick2_gap_a: assert property (ticksOut.tick2 |-> ##[100:150] ticksOut.tick2)
      else $error("2 MHz tick spacing wrong");
endmodule

/* verif/tsc_arrival_stamp_bench.sv */
// self-checking bench for the arrival stamp block
`timescale 1ns/1ps
`include "tsc_consts.svh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin mismatches++; \
   $display("[ERR] %s exp %h got %h", nm, ex, got); end end

module tsc_arrival_stamp_bench;
   logic                  core_clk = 1'b0;
   logic                  rst_n = 1'b0;
   tsc_pkg::tsc_bus_req_t busReq = '0;
   logic [31:0]           busRdata;
   logic [3:0]            trg = 4'h0;
   logic                  extEn = 1'b0;
   logic                  ext10Pin;
   logic                  stampClkOut;
   logic                  ref10OutA;
   logic                  ref10OutB;
   tsc_pkg::tsc_ticks_t   ticksOut;
   tsc_pkg::tsc_entry_t   e;
   logic [31:0]           rv;
   logic [31:0]           lo;
   int                    n;
   int                    mismatches = 0;
   int                    tests_run = 0;

   always #2 core_clk = ~core_clk;

   tsc_ext_ref i_ref (.en(extEn), .ext10Pin(ext10Pin));

   tsc_arrival_stamp i_dut (
      .core_clk(core_clk), .rst_n(rst_n), .busReq(busReq), .busRdata(busRdata),
      .blank1Pin(trg[0]), .blank2Pin(trg[1]), .ppsPin(trg[2]), .ext10Pin(ext10Pin),
      .arrayStrobe(trg[3]), .stampClkOut(stampClkOut), .ref10OutA(ref10OutA),
      .ref10OutB(ref10OutB), .ticksOut(ticksOut));

   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk);
   endtask

   // one strobe, one idle cycle; rv holds what the answer cycle showed
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      busReq <= '{a, d, w, !w};
      @(posedge core_clk);
      busReq <= '0;
      @(posedge core_clk);
      rv = busRdata;
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      cyc(20000);
      mismatches++;
      final_report();
   end

   initial begin
      cyc(16);
      rst_n <= 1'b1;
      cyc(1);
      bus(0, `TSC_OFF_CHK_END, 0);
      `CHK("chk end", 32'h0000_2710, rv)
      bus(0, `TSC_OFF_TRIG_CTRL, 0);
      `CHK("trig ctrl", 32'h0, rv)
      bus(0, 8'hFC, 0);
      `CHK("unmapped", 32'h0, rv)
      $display("test reset done");

      bus(1, `TSC_OFF_TOA_LOW, 32'h14);
      bus(1, `TSC_OFF_TOA_HIGH, 32'h5);
      bus(1, `TSC_OFF_TOA_CTRL, 32'h2);
      bus(0, `TSC_OFF_TOA_LOW, 0);
      `CHK("low preset", 32'h14, rv)
      bus(0, `TSC_OFF_TOA_HIGH, 0);
      `CHK("high preset", 32'h5, rv)
      // about 100 running cycles, one low step every other cycle
      bus(1, `TSC_OFF_TOA_CTRL, 32'h1);
      cyc(98);
      bus(1, `TSC_OFF_TOA_CTRL, 32'h0);
      bus(0, `TSC_OFF_TOA_LOW, 0);
      lo = rv;
      `CHK("low wrap", 1'b1, lo <= 32'h18)
      bus(0, `TSC_OFF_TOA_HIGH, 0);
      lo = rv * 32'h19 + lo;
      `CHK("count", 1'b1, lo >= 32'hC1 && lo <= 32'hC5)
      $display("test counter done");

      bus(1, `TSC_OFF_TOA_LOW, 32'h13);
      bus(1, `TSC_OFF_TOA_HIGH, 32'h0ABCDEF);
      bus(1, `TSC_OFF_TOA_CTRL, 32'h2);
      for (int b = 0; b < 8; b++) begin
         bus(1, `TSC_OFF_TRIG_CTRL, 32'h1 << b);
         trg <= 4'h1 << (b / 2);
         cyc(12);
         trg <= 4'h0;
         cyc(12);
         e = '{8'h1 << b, 28'h0ABCDEF, 5'h13};
         bus(0, `TSC_OFF_FIFO_LO, 0);
         `CHK("entry low", e[31:0], rv)
         bus(0, `TSC_OFF_FIFO_HI, 0);
         `CHK("entry high", {20'h0, 3'b101, e[40:32]}, rv)
         // give a second entry time to reach the hold, so it would show as valid
         cyc(2);
         bus(0, `TSC_OFF_FIFO_HI, 0);
         `CHK("single capture", 32'h200, rv)
      end
      $display("test triggers done");

      // both edges of the array strobe, more edges than the store holds
      bus(1, `TSC_OFF_TRIG_CTRL, 32'hC0);
      for (int i = 0; i < 20; i++) begin
         trg <= {~trg[3], 3'h0};
         cyc(2);
      end
      bus(0, `TSC_OFF_FIFO_HI, 0);
      `CHK("full word", 32'hC80, rv)
      n = 1;
      for (int i = 0; i < 20; i++) begin
         // next entry reaches the hold two cycles after the high-word read
         cyc(1);
         bus(0, `TSC_OFF_FIFO_LO, 0);
         lo = rv;
         bus(0, `TSC_OFF_FIFO_HI, 0);
         if (rv[11] === 1'b1) begin
            n++;
            `CHK("drain low", e[31:0], lo)
            `CHK("drain cause", 1'b1, rv[8:1] == 8'h40 || rv[8:1] == 8'h80)
         end
      end
      `CHK("kept entries", 1'b1, n == 16 || n == 17)
      bus(0, `TSC_OFF_FIFO_HI, 0);
      `CHK("drained", 32'h200, rv)
      $display("test full done");

      extEn <= 1'b1;
      bus(1, `TSC_OFF_CHK_END, 32'hA);
      bus(1, `TSC_OFF_CHK_CTRL, 32'h2);
      bus(1, `TSC_OFF_CHK_CTRL, 32'h1);
      for (int i = 0; i < 200 && rv[3] !== 1'b1; i++) begin
         bus(0, `TSC_OFF_CHK_CTRL, 0);
      end
      if (rv[3] !== 1'b1) begin
         mismatches++;
         final_report();
      end
      bus(0, `TSC_OFF_CHK_INT, 0);
      `CHK("int count", 32'hA, rv)
      bus(0, `TSC_OFF_CHK_EXT, 0);
      `CHK("ext count", 1'b1, rv >= 32'h9 && rv <= 32'hB)
      cyc(60);
      bus(0, `TSC_OFF_CHK_INT, 0);
      `CHK("int stopped", 32'hA, rv)
      bus(1, `TSC_OFF_CHK_CTRL, 32'h4);
      bus(0, `TSC_OFF_CHK_CTRL, 0);
      `CHK("ref select", 32'hC, rv)
      cyc(300);
      $display("test reference done");
      final_report();
   end
endmodule

bind tsc_arrival_stamp tsc_stamp_checker i_chk (
   .core_clk(core_clk), .rst_n(rst_n), .busReq(busReq), .busRdata(busRdata),
   .stampClkOut(stampClkOut), .ref10OutA(ref10OutA), .ref10OutB(ref10OutB),
   .ticksOut(ticksOut));
